// ===== logic/sdp_defs.svh
// offsets, field positions, reset values and timing counts of the supply diagnostic block
`ifndef SDP_DEFS_SVH
`define SDP_DEFS_SVH
`define SDP_CLK_HZ 25000000
`define SDP_TICK_MS 1
`define SDP_REFRESH_MS 50
`define SDP_STRETCH_MS 250
`define SDP_GLITCH_MS 1
`define SDP_WINDOW_MIN 2
`define SDP_MIN_MS 60000
`define SDP_CYC_PER_MS ((`SDP_CLK_HZ / 1000) * `SDP_TICK_MS)
`define SDP_TEMP_MIN (-45)
`define SDP_TEMP_MAX 150
`define SDP_OPH_MAX 262800
`define SDP_MIN_MAX 59
`define SDP_CNT_MAX 7200000
`define SDP_UPH_MAX 1000000
`define SDP_VIN_MAX 1130
`define SDP_VOUT_MAX 40
`define SDP_GOOD_PCT 90
`define SDP_DIP_PCT 90
`define SDP_RESERVE_PCT 105
`define SDP_LIFE_FULL 100
`define SDP_A_LIFE 8'h00
`define SDP_A_T_AIR 8'h01
`define SDP_A_T_AIR_MAX 8'h02
`define SDP_A_T_PRI 8'h03
`define SDP_A_T_PRI_MAX 8'h04
`define SDP_A_OP_HOURS 8'h05
`define SDP_A_OP_MIN 8'h06
`define SDP_A_TR_TOTAL 8'h07
`define SDP_A_TR_WINDOW 8'h08
`define SDP_A_VIN 8'h09
`define SDP_A_VOUT 8'h0a
`define SDP_A_TURN_ONS 8'h0b
`define SDP_A_UP_HOURS 8'h0c
`define SDP_A_UP_MIN 8'h0d
`define SDP_A_NVM_STATUS 8'h0e
`define SDP_A_SHUTDOWN 8'h0f
`define SDP_A_PARALLEL 8'h10
`define SDP_A_SETPOINT 8'h11
`define SDP_A_EVENTS 8'h12
`define SDP_NVM_GOOD 2'h0
`define SDP_NVM_RECOVER 2'h1
`define SDP_NVM_FATAL 2'h2
`define SDP_EV_GOOD 0
`define SDP_EV_DIP 1
`define SDP_EV_RESERVE 2
`define SDP_EV_OT_CAP 3
`define SDP_EV_OT_AIR 4
`define SDP_EV_N 5
`endif

// ===== logic/sdp_pkg.sv
// types of the supply diagnostic block
`include "sdp_defs.svh"
package sdp_pkg;
	typedef enum logic [1:0] {
		SDP_DIP_IDLE = 2'b00,
		SDP_DIP_QUAL = 2'b01,
		SDP_DIP_HOLD = 2'b10
	} sdp_dip_state_type;
	typedef struct packed {
		logic signed [15:0] t_air;
		logic signed [15:0] t_pri;
		logic [15:0] vin;
		logic [15:0] vout;
		logic [15:0] setpoint;
		logic [15:0] iout_pct;
		logic reserve_active;
		logic ot_cap;
		logic ot_air;
		logic cap_hot;
	} sdp_meas_type;
	typedef struct packed {
		logic [31:0] hours;
		logic [5:0] minutes;
		logic [31:0] turn_ons;
		logic [31:0] tr_total;
		logic [1:0] status;
		logic [7:0] life;
	} sdp_nvm_type;
endpackage

// ===== logic/sdp_core.sv
// supply diagnostic parameter bank with event generation
`include "sdp_defs.svh"
// Functional notes
// - lifetime percent only falls, faster when hot
// - airflow temperature signed, -45 to 150
// - airflow peak hold restarted each turn-on
// - primary temperature clamped -45 to 150
// - primary peak hold restarted each turn-on
// - operating hours persisted, capped 262800
// - operating minutes to 59, carry hours
// - transients lifetime and two-minute, capped
// - input voltage read-only, capped 1130
// - output voltage to 40, backfeed flag
// - turn-on counter persisted, capped 7200000
// - uptime hours since boot, capped 1000000
// - uptime minutes to 59, carry hours
// - memory status 0 good, 1, 2
// - shutdown 1 turns output off
// - parallel mode 0 single, 1 shared
// - output good at 90 percent setpoint
// - dip warning below 90 percent setpoint
// - dip warning stretched to 250 ms
// - dips under 1 ms ignored
// - reserve event above 105 percent current
// - separate capacitor and airflow overtemp events
// - parameter snapshot refreshed every 50 ms
module sdp_core
	import sdp_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = `SDP_CYC_PER_MS,
	parameter int unsigned LIFE_MIN_NORMAL = 600,
	parameter int unsigned LIFE_MIN_HOT = 60
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire logic rd_i,
	output logic [31:0] rdata_o,
	input wire sdp_meas_type meas_i,
	input wire sdp_nvm_type nvm_i,
	input wire logic transient_i,
	output sdp_nvm_type nvm_o,
	output logic shutdown_o,
	output logic parallel_o,
	output logic backfeed_o,
	output logic [`SDP_EV_N-1:0] event_o
);
	// refuse parameter values that the counters cannot hold
	if (CYC_PER_MS < 1 || CYC_PER_MS > 33554432) begin : g_bad_cyc
		$error("sdp_core: CYC_PER_MS must lie in 1 to 33554432");
	end
	if (LIFE_MIN_NORMAL < 1 || LIFE_MIN_NORMAL > 65535) begin : g_bad_life
		$error("sdp_core: LIFE_MIN_NORMAL must lie in 1 to 65535");
	end
	if (LIFE_MIN_HOT < 1 || LIFE_MIN_HOT > LIFE_MIN_NORMAL) begin : g_bad_hot
		$error("sdp_core: LIFE_MIN_HOT must lie in 1 to LIFE_MIN_NORMAL");
	end
	if (`SDP_STRETCH_MS > 255 || `SDP_GLITCH_MS > 254) begin : g_bad_dip
		$error("sdp_core: dip timing does not fit its counter");
	end
	function automatic logic signed [15:0] clamp_temp(input logic signed [15:0] t);
		if (t < 16'(`SDP_TEMP_MIN))
			return 16'(`SDP_TEMP_MIN);
		else if (t > 16'(`SDP_TEMP_MAX))
			return 16'(`SDP_TEMP_MAX);
		else
			return t;
	endfunction
	function automatic logic [15:0] cap_u16(input logic [15:0] v, input logic [15:0] m);
		return (v > m) ? m : v;
	endfunction
	function automatic logic [31:0] sat_inc(input logic [31:0] v, input logic [31:0] m);
		return (v >= m) ? m : v + 32'h1;
	endfunction
	// write strobe aimed at one register index
	function automatic logic wr_hit(input logic w, input logic [7:0] a, input logic [7:0] idx);
		return w && (a == idx);
	endfunction
	// minute field at its last value, carry into hours
	function automatic logic min_wrap(input logic [5:0] m);
		return m >= 6'(`SDP_MIN_MAX);
	endfunction
	// synchronise the transient pulse input
	logic tr_s1, tr_s2, tr_s3;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tr_s1 <= 1'b0;
			tr_s2 <= 1'b0;
			tr_s3 <= 1'b0;
		end else begin
			tr_s1 <= transient_i;
			tr_s2 <= tr_s1;
			tr_s3 <= tr_s2;
		end
	end
	// count rising edges only
	wire tr_pulse = tr_s2 & ~tr_s3;
	// millisecond, minute and refresh ticks
	localparam logic [15:0] MIN_LAST = 16'(`SDP_MIN_MS - 1);
	logic [24:0] ms_cnt;
	logic [15:0] min_ms;
	logic [5:0] ref_ms;
	logic [0:0] win_min;
	wire ms_tick = (ms_cnt == 25'(CYC_PER_MS - 1));
	wire min_tick = ms_tick && (min_ms == MIN_LAST);
	wire ref_tick = ms_tick && (ref_ms == 6'(`SDP_REFRESH_MS - 1));
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			ms_cnt <= 25'h0;
			min_ms <= 16'h0;
			ref_ms <= 6'h0;
			win_min <= 1'b0;
		end else begin
			ms_cnt <= ms_tick ? 25'h0 : ms_cnt + 25'h1;
			if (ms_tick) begin
				min_ms <= (min_ms == MIN_LAST) ? 16'h0 : min_ms + 16'h1;
				ref_ms <= (ref_ms == 6'(`SDP_REFRESH_MS - 1)) ? 6'h0 : ref_ms + 6'h1;
			end
			// two-minute window phase
			if (min_tick)
				win_min <= 1'(win_min + 1'b1);
		end
	end
	// snapshot of measurements, refreshed every 50 ms
	logic loaded;
	sdp_nvm_type nv;
	logic signed [15:0] t_air, t_pri, t_air_max, t_pri_max;
	logic [15:0] vin, vout, setpoint;
	logic [31:0] up_hours, tr_window, tr_acc;
	logic [5:0] up_min;
	logic [15:0] life_min;
	logic [7:0] life;
	// temperatures clamped to the reported range
	wire signed [15:0] air_c = clamp_temp(meas_i.t_air);
	wire signed [15:0] pri_c = clamp_temp(meas_i.t_pri);
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			t_air <= 16'h0;
			t_pri <= 16'h0;
			vin <= 16'h0;
			vout <= 16'h0;
			setpoint <= 16'h0;
			t_air_max <= 16'(`SDP_TEMP_MIN);
			t_pri_max <= 16'(`SDP_TEMP_MIN);
		end else if (ref_tick) begin
			t_air <= air_c;
			t_pri <= pri_c;
			vin <= cap_u16(meas_i.vin, 16'(`SDP_VIN_MAX));
			vout <= cap_u16(meas_i.vout, 16'(`SDP_VOUT_MAX));
			setpoint <= meas_i.setpoint;
			if (air_c > t_air_max)
				t_air_max <= air_c;
			if (pri_c > t_pri_max)
				t_pri_max <= pri_c;
		end
	end
	// counters kept in nonvolatile memory; loaded once after boot
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			loaded <= 1'b0;
			nv <= '0;
		end else if (!loaded) begin
			loaded <= 1'b1;
			nv <= nvm_i;
			nv.turn_ons <= sat_inc(nvm_i.turn_ons, 32'(`SDP_CNT_MAX));
			nv.status <= (nvm_i.status > `SDP_NVM_FATAL) ? `SDP_NVM_FATAL : nvm_i.status;
		end else begin
			if (tr_pulse)
				nv.tr_total <= sat_inc(nv.tr_total, 32'(`SDP_CNT_MAX));
			if (min_tick) begin
				if (min_wrap(nv.minutes)) begin
					nv.minutes <= 6'h0;
					nv.hours <= sat_inc(nv.hours, 32'(`SDP_OPH_MAX));
				end else
					nv.minutes <= nv.minutes + 6'h1;
			end
		end
	end
	// lifetime percent, one step per period of minutes
	wire [15:0] life_period = meas_i.cap_hot ? 16'(LIFE_MIN_HOT) : 16'(LIFE_MIN_NORMAL);
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			life <= 8'h0;
			life_min <= 16'h0;
		end else if (!loaded) begin
			life <= nvm_i.life;
			life_min <= 16'h0;
		end else if (min_tick) begin
			if (life_min + 16'h1 >= life_period) begin
				life_min <= 16'h0;
				if (life != 8'h0)
					life <= life - 8'h1;
			end else
				life_min <= life_min + 16'h1;
		end
	end
	// image written back to nonvolatile memory
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			nvm_o <= '0;
		else begin
			nvm_o <= nv;
			nvm_o.life <= life;
		end
	end
	// uptime since boot
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			up_hours <= 32'h0;
			up_min <= 6'h0;
		end else if (min_tick) begin
			if (min_wrap(up_min)) begin
				up_min <= 6'h0;
				up_hours <= sat_inc(up_hours, 32'(`SDP_UPH_MAX));
			end else
				up_min <= up_min + 6'h1;
		end
	end
	// transients over the last completed two-minute window
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			tr_acc <= 32'h0;
			tr_window <= 32'h0;
		end else if (min_tick && win_min == 1'b1) begin
			tr_window <= tr_acc;
			tr_acc <= tr_pulse ? 32'h1 : 32'h0;
		end else if (tr_pulse)
			tr_acc <= sat_inc(tr_acc, 32'(`SDP_CNT_MAX));
	end
	// writable controls
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			shutdown_o <= 1'b0;
			parallel_o <= 1'b0;
		end else begin
			if (wr_hit(wr_i, addr_i, `SDP_A_SHUTDOWN))
				shutdown_o <= wdata_i[0];
			if (wr_hit(wr_i, addr_i, `SDP_A_PARALLEL))
				parallel_o <= wdata_i[0];
		end
	end
	// event conditions
	wire [31:0] vout_pct = 32'(meas_i.vout) * 32'd100;
	wire [31:0] good_lim = 32'(meas_i.setpoint) * 32'(`SDP_GOOD_PCT);
	wire [31:0] dip_lim = 32'(meas_i.setpoint) * 32'(`SDP_DIP_PCT);
	wire good_cond = vout_pct >= good_lim;
	wire dip_raw = vout_pct < dip_lim;
	// output above setpoint means a back-feeding load
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			backfeed_o <= 1'b0;
		else
			backfeed_o <= meas_i.vout > meas_i.setpoint;
	end
	// dip qualification and stretching
	sdp_dip_state_type dip_st;
	logic [7:0] dip_ms;
	logic dip_warn;
	always_ff @(posedge clk_i) begin
		if (!rstn_i) begin
			dip_st <= SDP_DIP_IDLE;
			dip_ms <= 8'h0;
		end else begin
			case (dip_st)
				SDP_DIP_IDLE: begin
					dip_ms <= 8'h0;
					if (dip_raw)
						dip_st <= SDP_DIP_QUAL;
				end
				// dip must outlast the glitch filter
				SDP_DIP_QUAL: begin
					if (!dip_raw)
						dip_st <= SDP_DIP_IDLE;
					else if (ms_tick) begin
						if (dip_ms + 8'h1 >= 8'(`SDP_GLITCH_MS + 1)) begin
							dip_st <= SDP_DIP_HOLD;
							dip_ms <= 8'h0;
						end else
							dip_ms <= dip_ms + 8'h1;
					end
				end
				// hold the warning for the stretch time
				SDP_DIP_HOLD: begin
					if (ms_tick && dip_ms < 8'(`SDP_STRETCH_MS))
						dip_ms <= dip_ms + 8'h1;
					if (dip_ms >= 8'(`SDP_STRETCH_MS) && !dip_raw)
						dip_st <= SDP_DIP_IDLE;
				end
				default: dip_st <= SDP_DIP_IDLE;
			endcase
		end
	end
	assign dip_warn = (dip_st == SDP_DIP_HOLD);
	// conditions that raise events
	wire reserve_cond = meas_i.reserve_active && meas_i.iout_pct > 16'(`SDP_RESERVE_PCT);
	wire [`SDP_EV_N-1:0] ev_cond = {meas_i.ot_air, meas_i.ot_cap, reserve_cond, dip_warn, good_cond};
	// one edge detector per event bit
	logic [`SDP_EV_N-1:0] ev_prev;
	for (genvar gi = 0; gi < `SDP_EV_N; gi++) begin : g_event
		always_ff @(posedge clk_i) begin
			if (!rstn_i) begin
				ev_prev[gi] <= 1'b0;
				event_o[gi] <= 1'b0;
			end else begin
				ev_prev[gi] <= ev_cond[gi];
				event_o[gi] <= ev_cond[gi] & ~ev_prev[gi];
			end
		end
	end
	// register read port
	// read data stand one cycle, zero otherwise
	always_ff @(posedge clk_i) begin
		if (!rstn_i)
			rdata_o <= 32'h0;
		else if (rd_i) begin
			case (addr_i)
				`SDP_A_LIFE: rdata_o <= 32'(life);
				`SDP_A_T_AIR: rdata_o <= 32'(signed'(t_air));
				`SDP_A_T_AIR_MAX: rdata_o <= 32'(signed'(t_air_max));
				`SDP_A_T_PRI: rdata_o <= 32'(signed'(t_pri));
				`SDP_A_T_PRI_MAX: rdata_o <= 32'(signed'(t_pri_max));
				`SDP_A_OP_HOURS: rdata_o <= nv.hours;
				`SDP_A_OP_MIN: rdata_o <= 32'(nv.minutes);
				`SDP_A_TR_TOTAL: rdata_o <= nv.tr_total;
				`SDP_A_TR_WINDOW: rdata_o <= tr_window;
				`SDP_A_VIN: rdata_o <= 32'(vin);
				`SDP_A_VOUT: rdata_o <= 32'(vout);
				`SDP_A_TURN_ONS: rdata_o <= nv.turn_ons;
				`SDP_A_UP_HOURS: rdata_o <= up_hours;
				`SDP_A_UP_MIN: rdata_o <= 32'(up_min);
				`SDP_A_NVM_STATUS: rdata_o <= 32'(nv.status);
				`SDP_A_SHUTDOWN: rdata_o <= 32'(shutdown_o);
				`SDP_A_PARALLEL: rdata_o <= 32'(parallel_o);
				`SDP_A_SETPOINT: rdata_o <= 32'(setpoint);
				`SDP_A_EVENTS: rdata_o <= 32'({ev_cond, backfeed_o});
				default: rdata_o <= 32'h0;
			endcase
		end else
			rdata_o <= 32'h0;
	end
endmodule

// ===== tb/sdp_monitor.sv
// assertion checker bound to the supply diagnostic bank
`include "sdp_defs.svh"
module sdp_monitor
	import sdp_pkg::*;
#(
	parameter int unsigned CYC_PER_MS = 4
) (
	input wire logic clk_i,
	input wire logic rstn_i,
	input wire logic [7:0] addr_i,
	input wire logic [31:0] wdata_i,
	input wire logic wr_i,
	input wire sdp_meas_type meas_i,
	input wire logic shutdown_o,
	input wire logic parallel_o,
	input wire logic [`SDP_EV_N-1:0] event_o
);
	logic good;
	logic res;
	logic [3:0] dip_run;
	logic [31:0] since_dip;
	assign good = 32'(meas_i.vout) * 100 >= 32'(meas_i.setpoint) * 90;
	assign res = meas_i.reserve_active && (meas_i.iout_pct > 16'd105);
	always_ff @(posedge clk_i) begin
		if (!rstn_i) dip_run <= 4'h0;
		else if (good) dip_run <= 4'h0;
		else if (dip_run != 4'hf) dip_run <= dip_run + 4'h1;
	end
	always_ff @(posedge clk_i) begin
		if (!rstn_i) since_dip <= 32'hffff;
		else if (event_o[1]) since_dip <= 32'h0;
		else if (since_dip < 32'hffff) since_dip <= since_dip + 32'h1;
	end
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rstn_i);
	sequence s_wr(a);
		wr_i && addr_i == a;
	endsequence
	property p_shut_wr;
		s_wr(`SDP_A_SHUTDOWN) |=> shutdown_o == $past(wdata_i[0]);
	endproperty
	property p_shut_keep;
		!(wr_i && addr_i == `SDP_A_SHUTDOWN) |=> $stable(shutdown_o);
	endproperty
	property p_par_wr;
		s_wr(`SDP_A_PARALLEL) |=> parallel_o == $past(wdata_i[0]);
	endproperty
	property p_ev_once;
		|event_o |=> (event_o & $past(event_o)) == '0;
	endproperty
	property p_good;
		$rose(good) |=> event_o[0];
	endproperty
	property p_res;
		$rose(res) |=> event_o[2];
	endproperty
	property p_ot_cap;
		$rose(meas_i.ot_cap) |=> event_o[3];
	endproperty
	property p_ot_air;
		$rose(meas_i.ot_air) |=> event_o[4];
	endproperty
	property p_dip_glitch;
		event_o[1] |-> $past(dip_run) >= 4'h4;
	endproperty
	property p_dip_str;
		event_o[1] |-> since_dip >= 250 * CYC_PER_MS - 1;
	endproperty
	a_shut_wr: assert property (p_shut_wr)
		else $error("shutdown not set by write");
	a_shut_keep: assert property (p_shut_keep)
		else $error("shutdown changed without write");
	a_par_wr: assert property (p_par_wr)
		else $error("parallel mode not set by write");
	a_ev_once: assert property (p_ev_once)
		else $error("event longer than one cycle");
	a_good: assert property (p_good)
		else $error("output good event missing");
	a_res: assert property (p_res)
		else $error("reserve event missing");
	a_ot_cap: assert property (p_ot_cap)
		else $error("capacitor overtemp event missing");
	a_ot_air: assert property (p_ot_air)
		else $error("airflow overtemp event missing");
	a_dip_glitch: assert property (p_dip_glitch)
		else $error("dip warning on short dip");
	a_dip_str: assert property (p_dip_str)
		else $error("dip warning repeated inside hold");
endmodule
bind sdp_core sdp_monitor #(.CYC_PER_MS(CYC_PER_MS)) u_mon (.clk_i(clk_i), .rstn_i(rstn_i),
	.addr_i(addr_i), .wdata_i(wdata_i), .wr_i(wr_i), .meas_i(meas_i),
	.shutdown_o(shutdown_o), .parallel_o(parallel_o), .event_o(event_o));

// ===== tb/sdp_iol_master.sv
// bus master model standing in for the link master
module sdp_iol_master (
	input wire logic clk_i,
	output logic [7:0] addr_o,
	output logic [31:0] wdata_o,
	output logic wr_o,
	output logic rd_o
);
	timeunit 1ns;
	timeprecision 1ps;
	initial begin
		{addr_o, wdata_o, wr_o, rd_o} = '0;
	end
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		addr_o <= a;
		wdata_o <= d;
		wr_o <= 1'b1;
		@(posedge clk_i);
		wr_o <= 1'b0;
		@(posedge clk_i);
	endtask
	task automatic rd(input logic [7:0] a);
		addr_o <= a;
		rd_o <= 1'b1;
		@(posedge clk_i);
		rd_o <= 1'b0;
		@(posedge clk_i);
	endtask
endmodule

// ===== tb/tb_top.sv
// self-checking bench of the supply diagnostic bank
`include "sdp_defs.svh"
module tb_top
	import sdp_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;
	localparam int MS = 4;
	logic clk_i, rstn_i, wr, rd, trans, shut, par, bf, rd_q;
	logic [7:0] addr;
	logic [31:0] wdata, rdata, b;
	sdp_meas_type meas;
	sdp_nvm_type nvm, nvm_o;
	logic [`SDP_EV_N-1:0] ev;
	logic [31:0] exp_q[$];
	int error_cnt = 0;
	int samples_checked = 0;
	int ev_cnt[5] = '{default:0};
	int ta;
	int g;
	sdp_core #(.CYC_PER_MS(MS)) u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .addr_i(addr),
		.wdata_i(wdata), .wr_i(wr), .rd_i(rd), .rdata_o(rdata), .meas_i(meas), .nvm_i(nvm),
		.transient_i(trans), .nvm_o(nvm_o), .shutdown_o(shut), .parallel_o(par),
		.backfeed_o(bf), .event_o(ev));
	sdp_iol_master u_m (.clk_i(clk_i), .addr_o(addr), .wdata_o(wdata), .wr_o(wr), .rd_o(rd));
	initial begin
		clk_i = 1'b0;
		forever #20 clk_i = ~clk_i;
	end
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			error_cnt++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic complete_run;
		$display("checked %0d errors %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask
	task automatic cyc(input int n);
		repeat (n) @(posedge clk_i);
	endtask
	task automatic rd_exp(input logic [7:0] a, input logic [31:0] e);
		exp_q.push_back(e);
		u_m.rd(a);
	endtask
	task automatic rst(input int s);
		nvm.status <= 2'(s);
		nvm.turn_ons <= (s == 3) ? `SDP_CNT_MAX : 32'd7;
		rstn_i <= 1'b0;
		cyc(12);
		rstn_i <= 1'b1;
		cyc(1);
	endtask
	always @(posedge clk_i) begin
		rd_q <= rd;
		for (int i = 0; i < 5; i++) ev_cnt[i] += ev[i];
		if (rd_q) check(rdata, exp_q.pop_front());
	end
	initial begin
		cyc(100000);
		error_cnt++;
		complete_run();
	end
	initial begin
		rstn_i = 1'b0;
		trans = 1'b0;
		rd_q = 1'b0;
		meas = '0;
		nvm = '{hours:32'd100, minutes:6'd7, turn_ons:32'd7, tr_total:32'd10, status:2'h0,
			life:8'd80};
		void'($urandom(46));
		@(posedge clk_i);
		for (int s = 0; s < 4; s++) begin
			rst(s);
			rd_exp(`SDP_A_NVM_STATUS, (s > 2) ? 2 : s);
			rd_exp(`SDP_A_TURN_ONS, (s == 3) ? `SDP_CNT_MAX : 8);
			check(nvm_o.turn_ons, (s == 3) ? `SDP_CNT_MAX : 8);
		end
		rd_exp(`SDP_A_LIFE, 80);
		rd_exp(`SDP_A_UP_HOURS, 0);
		rd_exp(`SDP_A_UP_MIN, 0);
		rd_exp(`SDP_A_OP_HOURS, 100);
		rd_exp(`SDP_A_OP_MIN, 7);
		check(par, 0);
		for (int i = 0; i < 6; i++) begin
			b = $urandom % 2;
			u_m.wr(`SDP_A_SHUTDOWN, b);
			check(shut, b);
			u_m.wr(`SDP_A_PARALLEL, ~b);
			check(par, ~b & 1);
			rd_exp(`SDP_A_SHUTDOWN, b);
		end
		u_m.wr(`SDP_A_VIN, 5);
		rd_exp(8'hff, 0);
		rd_exp(`SDP_A_VIN, 0);
		ta = $urandom_range(150, 20);
		meas.setpoint <= 16'd24;
		meas.vout <= 16'd22;
		meas.t_air <= 16'(ta);
		meas.t_pri <= 16'sd200;
		meas.vin <= 16'd2000;
		repeat (3) begin
			trans <= 1'b1;
			cyc(3);
			trans <= 1'b0;
			cyc(3);
		end
		cyc(420);
		rd_exp(`SDP_A_T_AIR, ta);
		rd_exp(`SDP_A_T_PRI, 150);
		rd_exp(`SDP_A_VIN, 1130);
		rd_exp(`SDP_A_TR_TOTAL, 13);
		rd_exp(`SDP_A_SETPOINT, 24);
		meas.vout <= 16'd20;
		cyc(3);
		meas.vout <= 16'd22;
		cyc(20);
		check(ev_cnt[1], 0);
		g = ev_cnt[0];
		for (int i = 0; i < 2; i++) begin
			meas.vout <= 16'd20;
			cyc(40);
			meas.vout <= 16'd22;
			cyc(20);
			check(ev_cnt[1], 1);
		end
		check(ev_cnt[0], g + 2);
		meas.reserve_active <= 1'b1;
		meas.iout_pct <= 16'd105;
		cyc(3);
		meas.iout_pct <= 16'd106;
		meas.ot_cap <= 1'b1;
		meas.ot_air <= 1'b1;
		cyc(10);
		check(ev_cnt[2], 1);
		check(ev_cnt[3] * 2 + ev_cnt[4], 3);
		meas.vout <= 16'd50;
		meas.t_air <= -16'sd45;
		meas.t_pri <= -16'sd100;
		cyc(420);
		check(bf, 1);
		rd_exp(`SDP_A_VOUT, 40);
		rd_exp(`SDP_A_T_AIR_MAX, ta);
		rd_exp(`SDP_A_T_PRI, -45);
		rd_exp(`SDP_A_T_PRI_MAX, 150);
		rst(0);
		cyc(420);
		rd_exp(`SDP_A_T_AIR_MAX, -45);
		rd_exp(`SDP_A_T_PRI_MAX, -45);
		cyc(2);
		complete_run();
	end
endmodule
